// File: hdl/utxi_top.sv
// uart transmit path with interrupt requests for the whole unit
// assumes a baud tick from an outside generator on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "utxi_defines.svh"

// What this block does
// - three requests: rx error, rx done, tx done, ranked in that order
// - rx error request is OR of errors; merge bit reroutes to rx done
// - no rx requests while reception is disabled
// - rx done raised when a frame moves into rx holding buffer
// - tx done raised per frame of 7 or 8 bit character
// - full duplex; frame of start, data, parity, stop per mode register
// - character bits go least significant first
// - line goes high idle once unit enable is set
// - tx enable selects state; holding buffer write starts sending
// - start sends holding buffer via shift register, framing bits added
// - tx done fires as the final stop bit begins
// - with no new character the line stays idle after a frame
// - no tx done when shift register empties through reset
// - holding buffer free again once shifting begins
// - buffer full flag: 0 writable, 1 not writable
// - flag pair steps 10, 11, 01 in continuous sending
// - shift active flag: 1 while sending, 0 when done
// - holding buffer writes ignored while tx disabled
// - holding buffer is 8 bits, resets to FFH
// - clearing unit or tx enable forces shift active to 0
module utxi_top
  import utxi_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  // register port
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // bit timing
  input  wire logic       i_baud_tick,
  // serial line
  input  wire logic       i_serial_in_pin,
  output logic            o_serial_out_pin,
  // interrupt requests
  output logic            o_rx_error_irq,
  output logic            o_rx_done_irq,
  output logic            o_tx_done_irq
);

  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [1:0] p,
                                   input logic       c8);
    logic [7:0] m;
    m = c8 ? d : {1'b0, d[6:0]};
    unique case (p)
      `UTXI_PAR_EVEN: par_bit = ^m;
      `UTXI_PAR_ODD:  par_bit = ~^m;
      default:        par_bit = 1'b0;
    endcase
  endfunction : par_bit

  // register and transmit state
  utxi_mode_s mode,      next_mode;
  utxi_tx_e   tx_st,     next_tx_st;
  logic [7:0] tx_hold,   next_tx_hold;
  logic [7:0] tx_sh,     next_tx_sh;
  logic [2:0] tx_cnt,    next_tx_cnt;
  logic       tx_full,   next_tx_full;
  logic       tx_act,    next_tx_act;
  logic       tx_pbit,   next_tx_pbit;
  logic       tx_s2,     next_tx_s2;
  logic       sout,      next_sout;
  logic       irq_tx,    next_irq_tx;
  logic [7:0] rdata,     next_rdata;
  // receive state
  utxi_rx_e   rx_st,     next_rx_st;
  logic [7:0] rx_sh,     next_rx_sh;
  logic [2:0] rx_cnt,    next_rx_cnt;
  logic       rx_pbad,   next_rx_pbad;
  logic [7:0] rx_hold,   next_rx_hold;
  logic       rx_full,   next_rx_full;
  utxi_err_s  rx_err,    next_rx_err;
  logic       irq_err,   next_irq_err;
  logic       irq_done,  next_irq_done;
  logic       rx_meta;
  logic       rx_line;

  logic       tx_on;
  logic       rx_on;
  logic       wr_txh;
  logic [7:0] rx_data;
  logic [2:0] last;

  assign tx_on   = mode.unit_enable_bit & mode.tx_enable_bit;
  assign rx_on   = mode.unit_enable_bit & mode.rx_enable_bit;
  assign wr_txh  = i_wr && (i_addr == `UTXI_A_TXH);
  assign last    = mode.char8 ? `UTXI_LAST8 : `UTXI_LAST7;
  // a 7-bit character sits in the top of the shifter
  assign rx_data = mode.char8 ? rx_sh : {1'b0, rx_sh[7:1]};

  always_comb begin
    next_mode    = mode;
    next_tx_st   = tx_st;
    next_tx_hold = tx_hold;
    next_tx_sh   = tx_sh;
    next_tx_cnt  = tx_cnt;
    next_tx_full = tx_full;
    next_tx_act  = tx_act;
    next_tx_pbit = tx_pbit;
    next_tx_s2   = tx_s2;
    next_sout    = sout;
    next_irq_tx  = 1'b0;
    next_rdata   = `UTXI_ZERO8;
    if (i_wr && (i_addr == `UTXI_A_MODE)) begin
      next_mode = utxi_mode_s'(i_wdata);
    end
    if (i_rd) begin
      unique case (i_addr)
        `UTXI_A_MODE: next_rdata = mode;
        `UTXI_A_TXH:  next_rdata = tx_hold;
        `UTXI_A_TXS:  next_rdata = {`UTXI_STAT_PAD, tx_full, tx_act};
        `UTXI_A_RXH:  next_rdata = rx_hold;
        `UTXI_A_RXE:  next_rdata = {`UTXI_ERR_PAD, rx_err};
        default:      next_rdata = `UTXI_ZERO8;
      endcase
    end
    if (!tx_on) begin
      next_tx_st   = TX_IDLE;
      next_tx_full = 1'b0;
      next_tx_act  = 1'b0;
      next_sout    = 1'b1;
    end else begin
      unique case (tx_st)
        TX_IDLE: begin
          // active rises while full still set
          if (tx_full) begin
            next_tx_act = 1'b1;
            next_tx_st  = TX_LOAD;
          end
        end
        TX_LOAD: begin
          next_tx_sh   = tx_hold;
          next_tx_full = 1'b0;
          next_tx_pbit = par_bit(tx_hold, mode.parity, mode.char8);
          next_tx_cnt  = 3'h0;
          next_tx_s2   = 1'b0;
          next_tx_st   = TX_START;
        end
        TX_START: begin
          if (i_baud_tick) begin
            next_sout  = 1'b0;
            next_tx_st = TX_DATA;
          end
        end
        TX_DATA: begin
          // lsb first; one bit per tick
          if (i_baud_tick) begin
            next_sout   = tx_sh[0];
            next_tx_sh  = {1'b1, tx_sh[7:1]};
            next_tx_cnt = tx_cnt + 3'h1;
            if (tx_cnt == last) begin
              next_tx_st = (mode.parity == `UTXI_PAR_NONE) ?
                           TX_STOP : TX_PAR;
            end
          end
        end
        TX_PAR: begin
          if (i_baud_tick) begin
            next_sout  = tx_pbit;
            next_tx_st = TX_STOP;
          end
        end
        TX_STOP: begin
          if (i_baud_tick) begin
            next_sout = 1'b1;
            if (mode.stop2 && !tx_s2) begin
              next_tx_s2 = 1'b1;
            end else begin
              // done with the final stop bit
              next_irq_tx = 1'b1;
              next_tx_act = tx_full;
              next_tx_st  = TX_IDLE;
            end
          end
        end
        default: next_tx_st = TX_IDLE;
      endcase
      // write starts sending only while on
      if (wr_txh) begin
        next_tx_hold = i_wdata;
        next_tx_full = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      mode     <= utxi_mode_s'(`UTXI_MODE_RST);
      tx_st    <= TX_IDLE;
      tx_hold  <= `UTXI_HOLD_RST;
      tx_sh    <= `UTXI_HOLD_RST;
      tx_cnt   <= 3'h0;
      tx_full  <= 1'b0;
      tx_act   <= 1'b0;
      tx_pbit  <= 1'b0;
      tx_s2    <= 1'b0;
      sout     <= 1'b1;
      irq_tx   <= 1'b0;
      rdata    <= `UTXI_ZERO8;
    end else begin
      mode     <= next_mode;
      tx_st    <= next_tx_st;
      tx_hold  <= next_tx_hold;
      tx_sh    <= next_tx_sh;
      tx_cnt   <= next_tx_cnt;
      tx_full  <= next_tx_full;
      tx_act   <= next_tx_act;
      tx_pbit  <= next_tx_pbit;
      tx_s2    <= next_tx_s2;
      sout     <= next_sout;
      irq_tx   <= next_irq_tx;
      rdata    <= next_rdata;
    end
  end

  // receiver samples once per tick, no mid-bit search: coarse by design
  always_comb begin
    next_rx_st    = rx_st;
    next_rx_sh    = rx_sh;
    next_rx_cnt   = rx_cnt;
    next_rx_pbad  = rx_pbad;
    next_rx_hold  = rx_hold;
    next_rx_full  = rx_full;
    next_rx_err   = rx_err;
    next_irq_err  = 1'b0;
    next_irq_done = 1'b0;
    if (i_rd && (i_addr == `UTXI_A_RXH)) begin
      next_rx_full = 1'b0;
    end
    if (i_rd && (i_addr == `UTXI_A_RXE)) begin
      next_rx_err = '0;
    end
    if (!mode.unit_enable_bit) begin
      next_rx_hold = `UTXI_HOLD_RST;
    end
    if (!rx_on) begin
      next_rx_st = RX_IDLE;
    end else if (i_baud_tick) begin
      unique case (rx_st)
        RX_IDLE: begin
          if (!rx_line) begin
            next_rx_cnt  = 3'h0;
            next_rx_pbad = 1'b0;
            next_rx_st   = RX_DATA;
          end
        end
        RX_DATA: begin
          next_rx_sh  = {rx_line, rx_sh[7:1]};
          next_rx_cnt = rx_cnt + 3'h1;
          if (rx_cnt == last) begin
            next_rx_st = (mode.parity == `UTXI_PAR_NONE) ?
                         RX_STOP : RX_PAR;
          end
        end
        RX_PAR: begin
          next_rx_pbad = rx_line !=
                         par_bit(rx_data, mode.parity, mode.char8);
          next_rx_st   = RX_STOP;
        end
        RX_STOP: begin
          // hardware set wins over a same-cycle read clear
          next_rx_err.overrun = next_rx_err.overrun | rx_full;
          next_rx_err.framing = next_rx_err.framing | !rx_line;
          next_rx_err.parity  = next_rx_err.parity | rx_pbad;
          if (!rx_full) begin
            next_rx_hold = rx_data;
            next_rx_full = 1'b1;
          end
          if ((rx_full | !rx_line | rx_pbad) &&
              !mode.error_irq_merge_bit) begin
            next_irq_err = 1'b1;
          end else begin
            next_irq_done = 1'b1;
          end
          next_rx_st = RX_IDLE;
        end
        default: next_rx_st = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      rx_meta  <= 1'b1;
      rx_line  <= 1'b1;
      rx_st    <= RX_IDLE;
      rx_sh    <= `UTXI_HOLD_RST;
      rx_cnt   <= 3'h0;
      rx_pbad  <= 1'b0;
      rx_hold  <= `UTXI_HOLD_RST;
      rx_full  <= 1'b0;
      rx_err   <= '0;
      irq_err  <= 1'b0;
      irq_done <= 1'b0;
    end else begin
      rx_meta  <= i_serial_in_pin;
      rx_line  <= rx_meta;
      rx_st    <= next_rx_st;
      rx_sh    <= next_rx_sh;
      rx_cnt   <= next_rx_cnt;
      rx_pbad  <= next_rx_pbad;
      rx_hold  <= next_rx_hold;
      rx_full  <= next_rx_full;
      rx_err   <= next_rx_err;
      irq_err  <= next_irq_err;
      irq_done <= next_irq_done;
    end
  end

  // separate lines, ranked error, done, tx by the controller
  assign o_rx_error_irq   = irq_err;
  assign o_rx_done_irq    = irq_done;
  assign o_tx_done_irq    = irq_tx;
  assign o_serial_out_pin = sout;
  assign o_rdata          = rdata;

  line_idle_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (tx_st == TX_IDLE) |-> o_serial_out_pin) else $error("line not idle");
  flags_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !tx_on |=> (!tx_act && !tx_full)) else $error("flags kept");
  tx_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !tx_on |=> !o_tx_done_irq) else $error("tx done while off");
  wr_ignore_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (!tx_on && wr_txh) |=> !tx_full) else $error("write taken");
  wr_take_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (tx_on && wr_txh) |=> (tx_full && tx_hold == $past(i_wdata)))
    else $error("write lost");
  pair_seq_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (tx_on && tx_st == TX_IDLE && tx_full && !tx_act)
    |=> (tx_act && tx_full) ##1 (tx_act || !tx_on))
    else $error("pair sequence");
  start_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (tx_on && tx_st == TX_START && i_baud_tick) |=> !o_serial_out_pin)
    else $error("no start bit");
  stop_done_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_tx_done_irq |-> (o_serial_out_pin && $past(tx_st) == TX_STOP))
    else $error("done off stop");
  rx_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !rx_on |=> (!o_rx_done_irq && !o_rx_error_irq))
    else $error("rx irq while off");
  stat_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_rd && i_addr == `UTXI_A_TXS)
    |=> o_rdata == {`UTXI_STAT_PAD, $past(tx_full), $past(tx_act)})
    else $error("status read");

endmodule : utxi_top
`default_nettype wire

// File: inc/utxi_defines.svh
// constants for the uart transmit and interrupt block
// assumes an 8-bit register port with a 3-bit word address
`ifndef UTXI_DEFINES_SVH
`define UTXI_DEFINES_SVH
`define UTXI_A_MODE   3'h0
`define UTXI_A_TXH    3'h1
`define UTXI_A_TXS    3'h2
`define UTXI_A_RXH    3'h3
`define UTXI_A_RXE    3'h4
`define UTXI_HOLD_RST 8'hFF
`define UTXI_MODE_RST 8'h00
`define UTXI_ZERO8    8'h00
`define UTXI_STAT_PAD 6'h00
`define UTXI_ERR_PAD  5'h00
`define UTXI_LAST7    3'h6
`define UTXI_LAST8    3'h7
`define UTXI_PAR_NONE 2'h0
`define UTXI_PAR_ZERO 2'h1
`define UTXI_PAR_ODD  2'h2
`define UTXI_PAR_EVEN 2'h3
`endif

// File: inc/utxi_pkg.sv
// types for the uart transmit and interrupt block
// assumes the defines header is compiled alongside
package utxi_pkg;
  // serial_mode_register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       unit_enable_bit;
    logic       tx_enable_bit;
    logic       rx_enable_bit;
    logic       error_irq_merge_bit;
    logic [1:0] parity;
    logic       char8;
    logic       stop2;
  } utxi_mode_s;
  // rx_error_status_register, low three bits
  typedef struct packed {
    logic overrun;
    logic framing;
    logic parity;
  } utxi_err_s;
  typedef enum logic [2:0] {
    TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_PAR, TX_STOP
  } utxi_tx_e;
  typedef enum logic [1:0] {
    RX_IDLE, RX_DATA, RX_PAR, RX_STOP
  } utxi_rx_e;
endpackage : utxi_pkg

// File: tb/utxi_remote_rx.sv
// remote serial receiver that decodes frames seen on the line
// assumes the bench hands it the frame format and the bit tick
`timescale 1ns/100ps
`default_nettype none
module utxi_remote_rx
  import utxi_pkg::*;
(
  // clock and bit timing
  input  wire logic       i_clk_sys,
  input  wire logic       i_baud_tick,
  // line and format
  input  wire logic       i_line,
  input  wire logic [1:0] i_parity,
  input  wire logic       i_char8,
  // decoded frame
  output logic      [7:0] o_byte,
  output logic            o_par_ok,
  output logic            o_stop_ok,
  output int              o_count
);
  logic [3:0] pos = 4'h0;
  logic [7:0] sh;
  logic       par;
  logic [3:0] nb;
  assign nb = i_char8 ? 4'h8 : 4'h7;
  initial o_count = 0;
  always @(posedge i_clk_sys) begin
    if (i_baud_tick) begin
      if (pos == 4'h0) begin
        if (!i_line) begin
          pos <= 4'h1;
          sh <= 8'h00;
          par <= 1'b0;
          o_par_ok <= 1'b1;
        end
      end else if (pos <= nb) begin
        sh[pos - 4'h1] <= i_line;
        par <= par ^ i_line;
        pos <= pos + 4'h1;
      end else if (pos == nb + 4'h1 && i_parity != 2'h0) begin
        o_par_ok <= (i_line == (i_parity[1] & (par ~^ i_parity[0])));
        pos <= pos + 4'h1;
      end else begin
        // only the first stop bit is judged
        o_stop_ok <= i_line;
        o_byte <= sh;
        o_count <= o_count + 1;
        pos <= 4'h0;
      end
    end
  end
endmodule : utxi_remote_rx
`default_nettype wire

// File: tb/utxi_top_tb.sv
// self-checking bench for the uart transmit and interrupt block
// assumes one 40 MHz clock and a baud tick every 8 cycles
`timescale 1ns/100ps
`default_nettype none
`include "utxi_defines.svh"
module utxi_top_tb
  import utxi_pkg::*;
;
  logic       clk_sys, nrst, wr, rd, baud_tick, ser_in, ser_out;
  logic       rxe_irq, rxd_irq, txd_irq, m_c8, par_ok, stop_ok;
  logic [2:0] addr, bcnt;
  logic [7:0] wdata, rdata, rbyte, d;
  logic [1:0] m_par;
  logic [7:0] vals [4] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A};
  int         rcount, n_tx, n_rxd, n_rxe, cycles, failures, cmp_count, k, i;

  utxi_top utxi_top_i (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_baud_tick(baud_tick), .i_serial_in_pin(ser_in),
    .o_serial_out_pin(ser_out), .o_rx_error_irq(rxe_irq),
    .o_rx_done_irq(rxd_irq), .o_tx_done_irq(txd_irq));
  utxi_remote_rx utxi_remote_rx_i (.i_clk_sys(clk_sys),
    .i_baud_tick(baud_tick), .i_line(ser_out), .i_parity(m_par),
    .i_char8(m_c8), .o_byte(rbyte), .o_par_ok(par_ok),
    .o_stop_ok(stop_ok), .o_count(rcount));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task final_report();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // one bit time is eight clocks
  always @(posedge clk_sys) begin
    bcnt <= bcnt + 3'h1;
    baud_tick <= (bcnt == 3'h6);
    cycles <= cycles + 1;
    n_tx <= n_tx + int'(txd_irq);
    n_rxd <= n_rxd + int'(rxd_irq);
    n_rxe <= n_rxe + int'(rxe_irq);
    if (txd_irq === 1'b1) check({7'h00, ser_out}, 8'h01);
    if (cycles == 30000) begin
      failures = failures + 1;
      final_report();
    end
  end

  function utxi_mode_s mode(logic u, t, r, m, logic [1:0] p, logic c8, s2);
    return utxi_mode_s'{u, t, r, m, p, c8, s2};
  endfunction : mode

  task wr_reg(input logic [2:0] a, input logic [7:0] v);
    // a write right after a write lets one edge pass first
    if (wr === 1'b1) @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [2:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk_sys);
  endtask : rd_reg

  task rd_chk(input logic [2:0] a, input logic [7:0] exp);
    rd_reg(a, d);
    check(d, exp);
  endtask : rd_chk

  task automatic wait_for(ref int c, input int t);
    for (int j = 0; j < 3000 && c < t; j++) @(posedge clk_sys);
    check(8'(c >= t), 8'h01);
  endtask : wait_for

  // polls until the holding buffer frees up
  task poll_free();
    for (int j = 0; j < 60; j++) begin
      rd_reg(`UTXI_A_TXS, d);
      if (d[1] === 1'b0) break;
    end
  endtask : poll_free

  task wait_tick();
    do @(posedge clk_sys); while (baud_tick !== 1'b1);
  endtask : wait_tick

  task automatic send_rx(input logic [7:0] b, input logic s);
    logic [9:0] f;
    f = {s, b, 1'b0};
    for (int j = 0; j < 10; j++) begin
      wait_tick();
      ser_in <= f[j];
    end
    wait_tick();
    ser_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : send_rx

  initial begin
    nrst = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ser_in = 1'b1;
    bcnt = 3'h0;
    baud_tick = 1'b0;
    m_par = 2'h0;
    m_c8 = 1'b1;
    cycles = 0;
    n_tx = 0;
    n_rxd = 0;
    n_rxe = 0;
    failures = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd_chk(`UTXI_A_TXH, 8'hFF);
    rd_chk(`UTXI_A_TXS, 8'h00);
    rd_chk(3'h5, 8'h00);
    wr_reg(`UTXI_A_MODE, mode(1, 0, 0, 0, 2'h0, 1, 0));
    wr_reg(`UTXI_A_TXH, 8'h3C);
    rd_chk(`UTXI_A_TXH, 8'hFF);
    rd_chk(`UTXI_A_TXS, 8'h00);
    check({7'h00, ser_out}, 8'h01);
    // every parity code, both lengths and stop widths
    for (i = 0; i < 4; i++) begin
      m_par = 2'(i);
      m_c8 = i[0];
      wr_reg(`UTXI_A_MODE, mode(1, 1, 0, 0, 2'(i), i[0], i[1]));
      k = rcount;
      wr_reg(`UTXI_A_TXH, vals[i]);
      rd_reg(`UTXI_A_TXS, d);
      check(d & 8'h02, 8'h02);
      wait_for(rcount, k + 1);
      check(rbyte, vals[i] & (m_c8 ? 8'hFF : 8'h7F));
      check({6'h00, par_ok, stop_ok}, 8'h03);
      repeat (24) @(posedge clk_sys);
      rd_chk(`UTXI_A_TXS, 8'h00);
    end
    // writes follow a zero buffer full flag
    m_par = 2'h0;
    m_c8 = 1'b1;
    wr_reg(`UTXI_A_MODE, mode(1, 1, 0, 0, 2'h0, 1, 0));
    k = n_tx;
    i = rcount;
    wr_reg(`UTXI_A_TXH, 8'h81);
    poll_free();
    check(d, 8'h01);
    wr_reg(`UTXI_A_TXH, 8'h7E);
    rd_chk(`UTXI_A_TXS, 8'h03);
    wait_for(n_tx, k + 1);
    poll_free();
    check(d, 8'h01);
    wr_reg(`UTXI_A_TXH, 8'h42);
    rd_chk(`UTXI_A_TXS, 8'h03);
    wait_for(n_tx, k + 3);
    wait_for(rcount, i + 3);
    check(rbyte, 8'h42);
    repeat (16) @(posedge clk_sys);
    rd_chk(`UTXI_A_TXS, 8'h00);
    // abort mid frame
    k = n_tx;
    wr_reg(`UTXI_A_TXH, 8'h99);
    repeat (30) @(posedge clk_sys);
    wr_reg(`UTXI_A_MODE, mode(1, 0, 0, 0, 2'h0, 1, 0));
    // flags drop one edge after the mode write lands
    @(posedge clk_sys);
    rd_chk(`UTXI_A_TXS, 8'h00);
    repeat (120) @(posedge clk_sys);
    check(8'(n_tx - k), 8'h00);
    // receive while sending
    wr_reg(`UTXI_A_MODE, mode(1, 1, 1, 0, 2'h0, 1, 0));
    k = n_rxd;
    i = rcount;
    wr_reg(`UTXI_A_TXH, 8'h5A);
    send_rx(8'hB4, 1'b1);
    check(8'(n_rxd - k), 8'h01);
    rd_chk(`UTXI_A_RXH, 8'hB4);
    wait_for(rcount, i + 1);
    check(rbyte, 8'h5A);
    k = n_rxe;
    send_rx(8'h11, 1'b0);
    check(8'(n_rxe - k), 8'h01);
    rd_chk(`UTXI_A_RXE, 8'h02);
    // unread byte still held: next frame overruns
    send_rx(8'h66, 1'b1);
    check(8'(n_rxe - k), 8'h02);
    rd_chk(`UTXI_A_RXE, 8'h04);
    rd_chk(`UTXI_A_RXH, 8'h11);
    wr_reg(`UTXI_A_MODE, mode(1, 0, 1, 1, 2'h0, 1, 0));
    i = n_rxd;
    send_rx(8'h22, 1'b0);
    check(8'(n_rxd - i), 8'h01);
    check(8'(n_rxe - k), 8'h02);
    rd_reg(`UTXI_A_RXE, d);
    rd_reg(`UTXI_A_RXH, d);
    wr_reg(`UTXI_A_MODE, mode(1, 0, 0, 0, 2'h0, 1, 0));
    send_rx(8'h33, 1'b0);
    send_rx(8'h44, 1'b1);
    check(8'(n_rxd - i + n_rxe - k), 8'h03);
    final_report();
  end
endmodule : utxi_top_tb
`default_nettype wire
